// ---- src/uart_top.sv ----
/*
 * Pin-controlled asynchronous serial transceiver with Wishbone status.
 * Assumes a single system clock; the 16x transmit and receive clocks are
 * inputs synchronous to it and are turned into enable pulses here.
 */
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Character length five to eight bits.
// - Odd or even parity, or none.
// - One, two, or 1.5 stop bits.
// - Receiver deframes and checks parity, stop.
// - Transmitter adds start, parity, stop bits.
// - Low load strobe captures eight data inputs.
// - Unused upper data inputs are ignored.
// - Load rising edge clears holding empty.
// - Idle shifter takes character within one cycle.
// - Each bit spans sixteen transmit clock periods.
// - Second character waits for current frame end.
// - Waiting character follows back to back.
// - Length select pins encode five to eight.
// - Stop select high gives 1.5 or two.
// - Parity disable suppresses parity and error.
// - Control load pulse latches format settings.
module uart_top (
    input  wire logic       SYS_CLK_I,
    input  wire logic       SRST_I,
    input  wire logic [7:0] TX_PARALLEL_IN_I,
    input  wire logic       TX_HOLDING_LOAD_N_I,
    input  wire logic       TX_BIT_CLOCK_16X_I,
    input  wire logic       RX_BIT_CLOCK_16X_I,
    input  wire logic       RX_SERIAL_I,
    input  wire logic [1:0] CHAR_LENGTH_SEL_I,
    input  wire logic       STOP_BIT_SEL_I,
    input  wire logic       PARITY_DISABLE_I,
    input  wire logic       PARITY_EVEN_I,
    input  wire logic       CTRL_WORD_LOAD_I,
    input  wire logic       WB_CYC_I,
    input  wire logic       WB_STB_I,
    input  wire logic       WB_WE_I,
    input  wire logic [3:0] WB_ADR_I,
    input  wire logic [3:0] WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]     WB_DAT_O,
    output logic            WB_ACK_O,
    output logic            SERIAL_TX_OUT_O,
    output logic            TX_HOLDING_EMPTY_O,
    output logic            TX_SHIFT_EMPTY_O,
    output logic [7:0]      RX_DATA_O,
    output logic            PARITY_ERR_O,
    output logic            FRAME_ERR_O,
    output logic            IRQ_O
);
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } tx_state_e;

    ////////////////////////////////////////////////////////////////////
    // Control word and clock enables.
    logic [5:0] ctrl_reg;
    logic       load_n_prev_reg;
    logic       txc_prev_reg;
    logic       rxc_prev_reg;
    logic [7:0] hold_reg;
    logic       hold_full_reg;
    wire        tx_tick = TX_BIT_CLOCK_16X_I & ~txc_prev_reg;
    wire        rx_tick = RX_BIT_CLOCK_16X_I & ~rxc_prev_reg;
    wire        load_rise = TX_HOLDING_LOAD_N_I & ~load_n_prev_reg;
    wire [1:0]  len = ctrl_reg[uart_pkg::CTRL_LEN_LSB +: 2];
    wire        two_stop = ctrl_reg[uart_pkg::CTRL_STOP];
    wire        par_dis = ctrl_reg[uart_pkg::CTRL_PAR_DIS];
    wire        par_even = ctrl_reg[uart_pkg::CTRL_PAR_EVEN];
    wire [7:0]  len_mask = 8'hFF >> (2'h3 - len);

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            ctrl_reg        <= uart_pkg::CTRL_RESET;
            load_n_prev_reg <= 1'b1;
            txc_prev_reg    <= 1'b0;
            rxc_prev_reg    <= 1'b0;
            hold_reg        <= 8'h00;
        end else begin
            load_n_prev_reg <= TX_HOLDING_LOAD_N_I;
            txc_prev_reg    <= TX_BIT_CLOCK_16X_I;
            rxc_prev_reg    <= RX_BIT_CLOCK_16X_I;
            if (CTRL_WORD_LOAD_I) begin
                ctrl_reg <= {1'b0, PARITY_EVEN_I, PARITY_DISABLE_I,
                             STOP_BIT_SEL_I, CHAR_LENGTH_SEL_I};
            end
            if (!TX_HOLDING_LOAD_N_I) begin
                hold_reg <= TX_PARALLEL_IN_I & len_mask;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter: holding buffer and shift sequencer.
    tx_state_e  tx_state_reg;
    logic [7:0] shift_reg;
    logic [3:0] tick_cnt_reg;
    logic [2:0] bit_idx_reg;
    logic       par_reg;
    logic       half_stop_reg;
    logic       tx_out_reg;
    wire        shifter_free = (tx_state_reg == TX_IDLE);
    wire        bit_end = tx_tick & (tick_cnt_reg == 4'hF);
    wire        half_end = tx_tick
                           & (tick_cnt_reg == 4'(uart_pkg::HALF_STOP - 1));
    wire [2:0]  last_idx = 3'(uart_pkg::BASE_LEN - 1) + {1'b0, len};
    wire        transfer = hold_full_reg & ~load_rise & shifter_free;
    wire        stop_done = (tx_state_reg == TX_STOP)
                            & ((half_stop_reg && len == uart_pkg::LEN_5)
                               ? half_end : bit_end);
    wire        stop_more = two_stop & ~half_stop_reg;

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            hold_full_reg <= 1'b0;
            tx_state_reg  <= TX_IDLE;
            shift_reg     <= 8'h00;
            tick_cnt_reg  <= 4'h0;
            bit_idx_reg   <= 3'h0;
            par_reg       <= 1'b0;
            half_stop_reg <= 1'b0;
            tx_out_reg    <= 1'b1;
        end else begin
            if (load_rise) begin
                hold_full_reg <= 1'b1;
            end else if (transfer) begin
                hold_full_reg <= 1'b0;
            end
            if (tx_tick) begin
                tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_out_reg <= 1'b1;
                    if (transfer) begin
                        shift_reg    <= hold_reg;
                        par_reg      <= ^hold_reg ^ ~par_even;
                        tick_cnt_reg <= 4'h0;
                        bit_idx_reg  <= 3'h0;
                        tx_out_reg   <= 1'b0;
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        tx_out_reg   <= shift_reg[0];
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (bit_end) begin
                        shift_reg   <= {1'b0, shift_reg[7:1]};
                        bit_idx_reg <= bit_idx_reg + 3'h1;
                        if (bit_idx_reg != last_idx) begin
                            tx_out_reg <= shift_reg[1];
                        end else if (!par_dis) begin
                            tx_out_reg   <= par_reg;
                            tx_state_reg <= TX_PAR;
                        end else begin
                            tx_out_reg    <= 1'b1;
                            half_stop_reg <= 1'b0;
                            tx_state_reg  <= TX_STOP;
                        end
                    end
                end
                TX_PAR: begin
                    if (bit_end) begin
                        tx_out_reg    <= 1'b1;
                        half_stop_reg <= 1'b0;
                        tx_state_reg  <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (stop_done) begin
                        tick_cnt_reg <= 4'h0;
                        if (stop_more) begin
                            half_stop_reg <= 1'b1;
                        end else begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    assign SERIAL_TX_OUT_O    = tx_out_reg;
    assign TX_HOLDING_EMPTY_O = ~hold_full_reg;
    assign TX_SHIFT_EMPTY_O   = shifter_free;

    ////////////////////////////////////////////////////////////////////
    // Receiver.
    logic       rx_done;
    logic       rx_perr;
    logic       rx_ferr;
    uart_rx u_rx (
        .clk_i      (SYS_CLK_I),
        .rst_i      (SRST_I),
        .tick_i     (rx_tick),
        .rx_i       (RX_SERIAL_I),
        .len_i      (len),
        .par_dis_i  (par_dis),
        .par_even_i (par_even),
        .data_o     (RX_DATA_O),
        .done_o     (rx_done),
        .par_err_o  (rx_perr),
        .frame_err_o(rx_ferr)
    );
    assign PARITY_ERR_O = rx_perr & ~par_dis;
    assign FRAME_ERR_O  = rx_ferr;

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave with sticky event status.
    logic [3:0] status_reg;
    logic [3:0] enable_reg;
    logic       ack_reg;
    logic [31:0] dat_reg;
    wire        req = WB_CYC_I & WB_STB_I & ~ack_reg;
    wire        wr  = req & WB_WE_I & WB_SEL_I[0];
    wire        clr_hit = wr & (WB_ADR_I == uart_pkg::ADR_CLEAR);
    wire        en_hit  = wr & (WB_ADR_I == uart_pkg::ADR_ENABLE);
    wire [3:0]  events  = {rx_done & rx_ferr, rx_done & rx_perr & ~par_dis,
                           rx_done, transfer};
    wire [3:0]  clr_bits = clr_hit ? WB_DAT_I[3:0] : 4'h0;
    wire [31:0] rd_data =
        (WB_ADR_I == uart_pkg::ADR_STATUS) ? {28'h0, status_reg} :
        (WB_ADR_I == uart_pkg::ADR_ENABLE) ? {28'h0, enable_reg} :
        (WB_ADR_I == uart_pkg::ADR_RXDATA) ? {24'h0, RX_DATA_O} :
        32'h0;

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            status_reg <= 4'h0;
            enable_reg <= 4'h0;
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0;
        end else begin
            ack_reg    <= req;
            dat_reg    <= req ? rd_data : 32'h0;
            status_reg <= (status_reg & ~clr_bits) | events;
            if (en_hit) begin
                enable_reg <= WB_DAT_I[3:0];
            end
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;
    assign IRQ_O    = |(status_reg & enable_reg);

    ////////////////////////////////////////////////////////////////////
    // Checks.
    a_load_clears_empty: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) load_rise |=> !TX_HOLDING_EMPTY_O)
        else $error("holding empty not cleared by load");
    a_idle_transfer: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) load_rise && shifter_free
        |=> ##[0:1] !TX_SHIFT_EMPTY_O)
        else $error("idle shifter did not take character");
    a_start_low: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) $rose(tx_state_reg == TX_START)
        |-> !SERIAL_TX_OUT_O)
        else $error("start bit not low");
    a_idle_high: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) (tx_state_reg == TX_IDLE) && !transfer
        |=> SERIAL_TX_OUT_O || !TX_SHIFT_EMPTY_O)
        else $error("line not idle high");
    a_hold_waits: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) hold_full_reg && !shifter_free
        |=> hold_full_reg)
        else $error("waiting character lost");
    a_back_to_back: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) stop_done && !stop_more && hold_full_reg
        |=> ##1 !TX_SHIFT_EMPTY_O)
        else $error("no back to back transfer");
    a_parity_off: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) rx_done && par_dis |-> !rx_perr)
        else $error("parity error while disabled");
    a_no_par_state: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) par_dis && tx_state_reg == TX_DATA
        |=> tx_state_reg != TX_PAR)
        else $error("parity sent while disabled");
    a_ctrl_latch: assert property (@(posedge SYS_CLK_I)
        disable iff (SRST_I) CTRL_WORD_LOAD_I
        |=> len == $past(CHAR_LENGTH_SEL_I))
        else $error("control word not latched");
    c_frame_sent: cover property (@(posedge SYS_CLK_I)
        stop_done && !stop_more);
    c_char_rx: cover property (@(posedge SYS_CLK_I) rx_done);
    c_back_to_back: cover property (@(posedge SYS_CLK_I)
        stop_done && hold_full_reg);
endmodule

// ---- include/uart_pkg.sv ----
/*
 * Shared constants of the pin-controlled serial transceiver.
 * Assumes one system clock; the 16x bit clocks are edge-detected into enable pulses.
 */
package uart_pkg;
    localparam int OVERSAMPLE     = 16;
    localparam int HALF_BIT       = 8;
    localparam int HALF_STOP      = 8;
    localparam int CNT_W          = 5;
    localparam int DATA_W         = 8;
    localparam int LEN_W          = 2;
    localparam logic [LEN_W-1:0] LEN_5 = 2'h0;
    localparam logic [LEN_W-1:0] LEN_8 = 2'h3;
    localparam int BASE_LEN       = 5;
    localparam logic [5:0] CTRL_RESET = 6'h03;
    localparam int CTRL_LEN_LSB   = 0;
    localparam int CTRL_STOP      = 2;
    localparam int CTRL_PAR_DIS   = 3;
    localparam int CTRL_PAR_EVEN  = 4;
    localparam int IRQ_W          = 4;
    localparam int IRQ_TX_EMPTY   = 0;
    localparam int IRQ_RX_READY   = 1;
    localparam int IRQ_PAR_ERR    = 2;
    localparam int IRQ_FRAME_ERR  = 3;
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_CLEAR  = 4'h4;
    localparam logic [3:0] ADR_ENABLE = 4'h8;
    localparam logic [3:0] ADR_RXDATA = 4'hC;
endpackage

// ---- src/uart_rx.sv ----
/*
 * Receive path: deframes one character at a time on 16x enable pulses.
 * Assumes the serial input is synchronous to the system clock.
 */
`timescale 1ns/1ps
module uart_rx (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       rx_i,
    input  wire logic [1:0] len_i,
    input  wire logic       par_dis_i,
    input  wire logic       par_even_i,
    output logic [7:0]      data_o,
    output logic            done_o,
    output logic            par_err_o,
    output logic            frame_err_o
);
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_e;

    rx_state_e   state_reg;
    logic [4:0]  cnt_reg;
    logic [3:0]  idx_reg;
    logic [8:0]  shift_reg;
    wire  [3:0]  nbits = 4'(uart_pkg::BASE_LEN) + {2'h0, len_i}
                         + {3'h0, ~par_dis_i};
    wire         mid   = (cnt_reg == 5'(uart_pkg::HALF_BIT - 1));
    wire         full  = (cnt_reg == 5'(uart_pkg::OVERSAMPLE - 1));
    wire  [7:0]  dmask = 8'hFF >> (2'h3 - len_i);
    wire  [8:0]  dfix  = (shift_reg >> (4'h9 - nbits)) & 9'h0FF;
    wire         pbit  = shift_reg[8];
    wire         pcalc = ^(dfix[7:0] & dmask) ^ ~par_even_i;

    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            state_reg   <= RX_IDLE;
            cnt_reg     <= 5'h00;
            idx_reg     <= 4'h0;
            shift_reg   <= 9'h000;
            data_o      <= 8'h00;
            par_err_o   <= 1'b0;
            frame_err_o <= 1'b0;
        end else if (tick_i) begin
            cnt_reg <= cnt_reg + 5'h01;
            case (state_reg)
                RX_IDLE: begin
                    cnt_reg <= 5'h00;
                    if (!rx_i) begin
                        state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (mid) begin
                        cnt_reg   <= 5'h00;
                        idx_reg   <= 4'h0;
                        state_reg <= rx_i ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (full) begin
                        cnt_reg   <= 5'h00;
                        shift_reg <= {rx_i, shift_reg[8:1]};
                        idx_reg   <= idx_reg + 4'h1;
                        if (idx_reg == nbits - 4'h1) begin
                            state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (full) begin
                        state_reg   <= RX_IDLE;
                        done_o      <= 1'b1;
                        data_o      <= dfix[7:0] & dmask;
                        frame_err_o <= ~rx_i;
                        par_err_o   <= ~par_dis_i
                                       & (pbit != pcalc);
                    end
                end
                default: state_reg <= RX_IDLE;
            endcase
        end
    end
endmodule

// ---- tb/serial_peer.sv ----
/*
 * Remote serial peer: sends frames to the receiver, decodes sent frames.
 * Assumes 16 ticks of 4 system cycles, so 64 system cycles a bit.
 */
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_CYC = 64
) (
    input  wire logic       clk_i,
    input  wire logic       line_i,
    input  wire logic [1:0] len_i,
    input  wire logic       par_dis_i,
    output logic            line_o
);
    int         cyc = 0;
    int         start_cyc = 0;
    int         mon_count = 0;
    logic [7:0] mon_data = 8'h00;
    logic       mon_par = 1'b0;
    logic       mon_stop = 1'b0;

    initial line_o = 1'b1;

    always @(posedge clk_i) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////
    // Samples the data, parity and first stop bit of an outgoing frame at their centres.
    always begin
        @(negedge line_i);
        @(posedge clk_i);
        start_cyc = cyc;
        repeat (BIT_CYC / 2 - 1) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            mon_data[i] = 1'b0;
            if (i < 5 + len_i) begin
                repeat (BIT_CYC) @(posedge clk_i);
                mon_data[i] = line_i;
            end
        end
        if (!par_dis_i) begin
            repeat (BIT_CYC) @(posedge clk_i);
            mon_par = line_i;
        end
        repeat (BIT_CYC) @(posedge clk_i);
        mon_stop = line_i;
        mon_count++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic put(input logic b);
        line_o <= b;
        repeat (BIT_CYC) @(posedge clk_i);
    endtask

    // Sends one frame; the flags spoil the parity or the first stop bit.
    task automatic send(input logic [7:0] d, input int nb, input logic pen,
                        input logic ev, input logic badp, input logic bads);
        logic p;
        p = !ev;
        put(1'b0);
        for (int i = 0; i < nb; i++) begin
            put(d[i]);
            p = p ^ d[i];
        end
        if (pen) put(p ^ badp);
        put(!bads);
        put(1'b1);
    endtask
endmodule

// ---- tb/uart_top_tb.sv ----
/*
 * Self-checking bench of the serial transceiver.
 * Assumes the peer model and a 16x tick of 4 system cycles.
 */
`timescale 1ns/1ps
module uart_top_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  tx_data = 8'h00;
    logic        load_n = 1'b1;
    logic        tick = 1'b0;
    logic [1:0]  len_sel = 2'h3;
    logic        stop_sel = 1'b0;
    logic        par_dis = 1'b0;
    logic        par_even = 1'b0;
    logic        ctrl_load = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic [31:0] q;
    logic [7:0]  rx_data;
    logic        ack;
    logic        tx_line;
    logic        rx_line;
    logic        hold_empty;
    logic        shift_empty;
    logic        perr;
    logic        ferr;
    logic        irq;
    int          n_mismatch = 0;
    int          n_tests = 0;

    uart_top u_dut (
        .SYS_CLK_I(clk), .SRST_I(srst), .TX_PARALLEL_IN_I(tx_data),
        .TX_HOLDING_LOAD_N_I(load_n), .TX_BIT_CLOCK_16X_I(tick),
        .RX_BIT_CLOCK_16X_I(tick), .RX_SERIAL_I(rx_line),
        .CHAR_LENGTH_SEL_I(len_sel), .STOP_BIT_SEL_I(stop_sel),
        .PARITY_DISABLE_I(par_dis), .PARITY_EVEN_I(par_even),
        .CTRL_WORD_LOAD_I(ctrl_load), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
        .WB_DAT_O(dat_r), .WB_ACK_O(ack), .SERIAL_TX_OUT_O(tx_line),
        .TX_HOLDING_EMPTY_O(hold_empty), .TX_SHIFT_EMPTY_O(shift_empty),
        .RX_DATA_O(rx_data), .PARITY_ERR_O(perr), .FRAME_ERR_O(ferr),
        .IRQ_O(irq)
    );

    serial_peer u_peer (
        .clk_i(clk), .line_i(tx_line), .len_i(len_sel),
        .par_dis_i(par_dis), .line_o(rx_line)
    );

    initial forever #25 clk = ~clk;

    always begin
        repeat (2) @(posedge clk);
        tick <= ~tick;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_r;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic set_fmt(input logic [1:0] l, input logic s,
                           input logic pd, input logic ev);
        len_sel <= l;
        stop_sel <= s;
        par_dis <= pd;
        par_even <= ev;
        ctrl_load <= 1'b1;
        repeat (2) @(posedge clk);
        ctrl_load <= 1'b0;
        @(posedge clk);
    endtask

    task automatic load_char(input logic [7:0] d, input logic idle);
        int n;
        tx_data <= d;
        load_n <= 1'b0;
        repeat (2) @(posedge clk);
        load_n <= 1'b1;
        @(posedge clk);
        tx_data <= ~d;
        for (n = 0; n < 4 && hold_empty !== 1'b0; n++) @(posedge clk);
        chk("holding full", 32'h0, 32'(hold_empty));
        if (idle) begin
            for (n = 0; n < 2 && shift_empty !== 1'b0; n++) @(posedge clk);
            chk("shifter busy", 32'h0, 32'(shift_empty));
            chk("holding free", 32'h1, 32'(hold_empty));
        end
    endtask

    task automatic wait_frame(input int n0);
        int n;
        for (n = 0; n < 3000 && u_peer.mon_count == n0; n++)
            @(posedge clk);
        chk("frame seen", 32'h1, 32'(n < 3000));
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        chk("tx idle", 32'h1, 32'(tx_line));
        chk("hold empty", 32'h1, 32'(hold_empty));
        chk("shift empty", 32'h1, 32'(shift_empty));
        chk("parity err", 32'h0, 32'(perr));
        chk("irq", 32'h0, 32'(irq));
    endtask

    task automatic test_tx();
        logic [7:0] d;
        logic [7:0] m;
        int         c;
        for (int i = 0; i < 4; i++) begin
            set_fmt(i[1:0], i[0], i == 1, i[1]);
            d = 8'hE6 ^ 8'(i * 53);
            m = d & (8'hFF >> (3 - i));
            c = u_peer.mon_count;
            load_char(d, 1'b1);
            wait_frame(c);
            chk("tx data", 32'(m), 32'(u_peer.mon_data));
            if (i != 1)
                chk("tx par", 32'((^m) ^ !i[1]), 32'(u_peer.mon_par));
            chk("tx stop", 32'h1, 32'(u_peer.mon_stop));
            for (c = 0; c < 500 && shift_empty !== 1'b1; c++)
                @(posedge clk);
        end
    endtask

    task automatic test_b2b();
        int c;
        int t0;
        set_fmt(uart_pkg::LEN_5, 1'b1, 1'b0, 1'b1);
        c = u_peer.mon_count;
        load_char(8'h15, 1'b1);
        repeat (100) @(posedge clk);
        load_char(8'h0A, 1'b0);
        wait_frame(c);
        chk("first", 32'h15, 32'(u_peer.mon_data));
        chk("queued", 32'h0, 32'(hold_empty));
        t0 = u_peer.start_cyc;
        wait_frame(c + 1);
        chk("second", 32'h0A, 32'(u_peer.mon_data));
        c = u_peer.start_cyc - t0;
        chk("spacing", 32'h1, 32'(c >= 542 && c <= 545));
    endtask

    task automatic test_rx();
        logic [9:0] lv = 10'h33F;
        logic [4:0] pd = 5'b00100;
        logic [4:0] ev = 5'b00111;
        logic [4:0] bp = 5'b00010;
        logic [4:0] bs = 5'b10000;
        logic [7:0] dv [5] = '{8'h3C, 8'hC5, 8'h5A, 8'hF3, 8'hA7};
        logic [1:0] l;
        for (int i = 0; i < 5; i++) begin
            l = lv[2*i+:2];
            set_fmt(l, 1'b0, pd[i], ev[i]);
            u_peer.send(dv[i], 5 + l, !pd[i], ev[i], bp[i], bs[i]);
            repeat (8) @(posedge clk);
            chk("rx data", 32'(dv[i] & (8'hFF >> (3 - l))), 32'(rx_data));
            chk("rx perr", 32'(bp[i]), 32'(perr));
            chk("rx ferr", 32'(bs[i]), 32'(ferr));
        end
    endtask

    task automatic test_irq();
        repeat (1000) @(posedge clk);
        wb(1'b1, uart_pkg::ADR_CLEAR, 4'hF, 32'hF);
        wb(1'b1, uart_pkg::ADR_ENABLE, 4'hF, 32'h0);
        set_fmt(uart_pkg::LEN_8, 1'b0, 1'b0, 1'b1);
        u_peer.send(8'h96, 8, 1'b1, 1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        wb(1'b0, uart_pkg::ADR_STATUS, 4'hF, 32'h0);
        chk("status", 32'h6, q);
        chk("irq masked", 32'h0, 32'(irq));
        wb(1'b1, uart_pkg::ADR_ENABLE, 4'h0, 32'h4);
        chk("irq no sel", 32'h0, 32'(irq));
        wb(1'b1, uart_pkg::ADR_ENABLE, 4'hF, 32'h4);
        chk("irq raised", 32'h1, 32'(irq));
        wb(1'b0, uart_pkg::ADR_ENABLE, 4'hF, 32'h0);
        chk("enable", 32'h4, q);
        wb(1'b1, uart_pkg::ADR_CLEAR, 4'hF, 32'h4);
        chk("irq cleared", 32'h0, 32'(irq));
        wb(1'b0, uart_pkg::ADR_STATUS, 4'hF, 32'h0);
        chk("status left", 32'h2, q);
        wb(1'b0, uart_pkg::ADR_RXDATA, 4'hF, 32'h0);
        chk("rx reg", 32'h96, q);
        wb(1'b0, 4'h1, 4'hF, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_tx();
        test_b2b();
        test_rx();
        test_irq();
        test_done();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule
